// File: core/sfdm_manager.v
// Diagnostic fault manager: gathers faults and encodes the output response
`timescale 1ns/10ps
`include "sfdm_regs.vh"

// Functional notes
// [R1] Range fault drives configured fault response
// [R2] Low supply forces fault response until clear
// [R3] Reset gives high-Z; hold data until delay
// [R4] High-supply response only when memory locked
// [R5] Unlocked high supply enters programming, high-Z
// [R6] High-voltage indication forces high impedance
// [R7] Overtemperature drives configured fault response
// [R8] Single-bit memory error corrected transparently
// [R9] Double-bit memory error faults, high-Z output
// [R10] Read data bits 0-25, bits 26-27 and 30-31 zero
// [R11] Read bit 28 marks corrected single error
// [R12] Read bit 29 marks double error
// [R13] PWM flag mode: half carrier, fixed duties
// [R14] SENT flag mode sets status nibble bits
// [R15] Logic or double-bit fault always high-Z
// [R16] High-Z style: any fault high-Z, PWM only
// [R17] Flag register holds one bit per fault except high voltage
// [R18] Data nibble fault bits for six faults
// [R19] Reporting gated by disables, lock, coil rate
// [R20] Protocol selectable PWM or SENT variants
// [R21] Config holds enables and response style
// [R22] High-Z beats coded; fixed PWM priority
// [R23] Controller decodes codes; high-Z unrecoverable
module sfdm_manager #(
   parameter PO_CYCLES = `SFDM_PO_CYCLES
)(
   // Clock and reset
   input wire ref_clk,
   input wire rst,
   // Fault indications
   input wire range_low,
   input wire range_high,
   input wire low_supply,
   input wire high_supply,
   input wire high_voltage,
   input wire over_temp,
   input wire analog_path_err,
   input wire logic_bist_err,
   // Configuration word
   input wire [3:0] proto_sel,
   input wire hiz_style,
   input wire nibble_report,
   input wire [2:0] lock_field,
   input wire [1:0] coil_rate,
   input wire ovd_dis,
   input wire uvd_dis,
   input wire otmp_dis,
   input wire oor_dis,
   input wire coilbist_dis,
   input wire lbist_dis,
   // Nonvolatile memory read path
   input wire mem_rd_valid,
   input wire [25:0] mem_raw_data,
   input wire [25:0] mem_syndrome,
   input wire mem_sbe,
   input wire mem_dbe,
   // Output response
   output reg out_hiz,
   output reg prog_mode,
   output reg fault_coded,
   output reg half_carrier,
   output reg [6:0] pwm_duty,
   output reg [3:0] status_comm_nibble,
   output reg [7:0] nibble_faults,
   output reg data_hold,
   output reg [7:0] diagnostic_flags,
   output reg mem_rd_ready,
   output reg [31:0] mem_rd_data
);

   localparam ST_POR = 3'h1;
   localparam ST_WAIT = 3'h2;
   localparam ST_RUN = 3'h4;

   reg [2:0] state;
   reg [2:0] next_state;
   reg [31:0] po_count;
   reg dbe_latched;
   wire locked;
   wire is_pwm;
   wire rep_ov;
   wire rep_uv;
   wire rep_ot;
   wire rep_rlo;
   wire rep_rhi;
   wire rep_ap;
   wire rep_lbist;
   wire any_coded;
   wire hard_hiz;
   reg [6:0] next_duty;

   assign locked = (lock_field == `SFDM_LOCK_VAL);
   assign is_pwm = (proto_sel == `SFDM_PROTO_PWM); // see [R20]
   // Reporting gates
   assign rep_ov = high_supply & ~ovd_dis & locked; // see [R19] see [R4]
   assign rep_uv = low_supply & ~uvd_dis; // see [R2] see [R19]
   assign rep_ot = over_temp & ~otmp_dis; // see [R7]
   assign rep_rlo = range_low & ~oor_dis; // see [R1]
   assign rep_rhi = range_high & ~oor_dis; // see [R1]
   assign rep_ap = analog_path_err & ~coilbist_dis &
      (coil_rate < `SFDM_COIL_LIMIT); // see [R19]
   assign rep_lbist = logic_bist_err & ~lbist_dis;
   assign any_coded = rep_ov | rep_uv | rep_ot | rep_rlo | rep_rhi | rep_ap;
   // Faults that always give high impedance
   assign hard_hiz = rep_lbist | dbe_latched | high_voltage |
      (high_supply & ~locked); // see [R15] see [R6] see [R5] see [R9]

   // Fixed PWM duty priority
   always @*
   begin
      next_duty = 7'h00;
      if (rep_ov)
         next_duty = `SFDM_DUTY_OV; // see [R22] see [R13]
      else if (rep_uv)
         next_duty = `SFDM_DUTY_UV;
      else if (rep_ap)
         next_duty = `SFDM_DUTY_AP;
      else if (rep_ot)
         next_duty = `SFDM_DUTY_OT;
      else if (rep_rlo)
         next_duty = `SFDM_DUTY_RLO;
      else if (rep_rhi)
         next_duty = `SFDM_DUTY_RHI;
   end

   // Power-on sequencing
   always @*
   begin
      case (state)
         ST_POR:
            next_state = ST_WAIT;
         ST_WAIT:
            if (po_count >= PO_CYCLES - 1)
               next_state = ST_RUN;
            else
               next_state = ST_WAIT;
         ST_RUN:
            next_state = ST_RUN;
         default:
            next_state = ST_POR;
      endcase
   end

   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state <= ST_POR;
         po_count <= 32'h00000000;
      end
      else
      begin
         state <= next_state;
         if (state == ST_WAIT)
            po_count <= po_count + 32'h00000001; // see [R3]
      end
   end

   // Double-bit fault is sticky until reset
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         dbe_latched <= 1'b0;
      else if (mem_rd_valid & mem_dbe)
         dbe_latched <= 1'b1; // see [R9]
   end

   // Memory read response
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         mem_rd_ready <= 1'b0;
         mem_rd_data <= 32'h00000000;
      end
      else
      begin
         mem_rd_ready <= mem_rd_valid;
         if (mem_rd_valid)
         begin
            mem_rd_data <= 32'h00000000; // see [R10]
            mem_rd_data[`SFDM_MEM_DATA_W-1:0] <= mem_sbe ?
               (mem_raw_data ^ mem_syndrome) : mem_raw_data; // see [R8]
            mem_rd_data[`SFDM_MEM_SBE_BIT] <= mem_sbe; // see [R11]
            mem_rd_data[`SFDM_MEM_DBE_BIT] <= mem_dbe; // see [R12]
         end
      end
   end

   // Output response and flags
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         out_hiz <= 1'b1;
         prog_mode <= 1'b0;
         fault_coded <= 1'b0;
         half_carrier <= 1'b0;
         pwm_duty <= 7'h00;
         status_comm_nibble <= 4'h0;
         nibble_faults <= 8'h00;
         data_hold <= 1'b1;
         diagnostic_flags <= 8'h00;
      end
      else
      begin
         prog_mode <= high_supply & ~locked; // see [R5]
         diagnostic_flags[`SFDM_FLAG_MEM2] <= dbe_latched; // see [R17]
         diagnostic_flags[`SFDM_FLAG_LBIST] <= rep_lbist;
         diagnostic_flags[`SFDM_FLAG_APATH] <= rep_ap;
         diagnostic_flags[`SFDM_FLAG_UV] <= rep_uv;
         diagnostic_flags[`SFDM_FLAG_OV] <= rep_ov;
         diagnostic_flags[`SFDM_FLAG_OT] <= rep_ot;
         diagnostic_flags[`SFDM_FLAG_RLO] <= rep_rlo;
         diagnostic_flags[`SFDM_FLAG_RHI] <= rep_rhi;
         nibble_faults <= 8'h00;
         if (nibble_report & ~is_pwm)
         begin
            nibble_faults[`SFDM_DN_RHI] <= rep_rhi; // see [R18]
            nibble_faults[`SFDM_DN_RLO] <= rep_rlo;
            nibble_faults[`SFDM_DN_OT] <= rep_ot;
            nibble_faults[`SFDM_DN_OV] <= rep_ov;
            nibble_faults[`SFDM_DN_UV] <= rep_uv;
            nibble_faults[`SFDM_DN_APATH] <= rep_ap;
         end
         // High-Z style only honoured with PWM
         out_hiz <= (state == ST_POR) | hard_hiz |
            (hiz_style & is_pwm & any_coded); // see [R16] see [R22]
         fault_coded <= any_coded & ~hard_hiz &
            ~(hiz_style & is_pwm); // see [R21]
         half_carrier <= is_pwm & ~hiz_style & any_coded & ~hard_hiz;
         pwm_duty <= (is_pwm & ~hiz_style) ? next_duty : 7'h00;
         status_comm_nibble <= 4'h0;
         if (~is_pwm)
         begin
            status_comm_nibble[`SFDM_SCN_FAULT] <= rep_ov | rep_uv |
               rep_ot | rep_rlo | rep_rhi; // see [R14]
            status_comm_nibble[`SFDM_SCN_APATH] <= rep_ap;
         end
         data_hold <= (state != ST_RUN); // see [R3]
      end
   end

endmodule

// File: core/sfdm_regs.vh
// Constants for the sensor fault diagnostic manager
`ifndef SFDM_REGS_VH
`define SFDM_REGS_VH
// Diagnostic flag bit positions
`define SFDM_FLAG_MEM2 0
`define SFDM_FLAG_LBIST 1
`define SFDM_FLAG_APATH 2
`define SFDM_FLAG_UV 3
`define SFDM_FLAG_OV 4
`define SFDM_FLAG_OT 5
`define SFDM_FLAG_RLO 6
`define SFDM_FLAG_RHI 7
// Data nibble 4/5 fault bit positions
`define SFDM_DN_RHI 0
`define SFDM_DN_RLO 1
`define SFDM_DN_OT 2
`define SFDM_DN_OV 3
`define SFDM_DN_UV 4
`define SFDM_DN_APATH 5
// Memory read response layout
`define SFDM_MEM_DATA_W 26
`define SFDM_MEM_SBE_BIT 28
`define SFDM_MEM_DBE_BIT 29
// Lock value enabling high-supply reporting
`define SFDM_LOCK_VAL 3'h5
// Coil rate limit for analog-path reporting
`define SFDM_COIL_LIMIT 2'h3
// Output protocol codes
`define SFDM_PROTO_PWM 4'h0
// PWM fault duty codes in percent
`define SFDM_DUTY_OV 7'h3C
`define SFDM_DUTY_UV 7'h28
`define SFDM_DUTY_AP 7'h1E
`define SFDM_DUTY_OT 7'h46
`define SFDM_DUTY_RLO 7'h50
`define SFDM_DUTY_RHI 7'h5A
// Status nibble bits
`define SFDM_SCN_APATH 0
`define SFDM_SCN_FAULT 1
// Power-on delay in microseconds and clock period in ns
`define SFDM_PO_DELAY_US 1000
`define SFDM_CLK_NS 40
`define SFDM_PO_CYCLES ((`SFDM_PO_DELAY_US * 1000 + `SFDM_CLK_NS - 1) / `SFDM_CLK_NS)
`endif

// File: tb/sfdm_monitor.sv
// Checker on the fault manager ports
`timescale 1ns/10ps
module sfdm_monitor (
   // Clock, reset and inputs
   input wire ref_clk,
   input wire rst,
   input wire low_supply,
   input wire uvd_dis,
   input wire high_voltage,
   input wire mem_rd_valid,
   input wire mem_dbe,
   // Outputs
   input wire out_hiz,
   input wire data_hold,
   input wire [7:0] diagnostic_flags,
   input wire mem_rd_ready,
   input wire [31:0] mem_rd_data
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_hv; high_voltage |=> out_hiz; endproperty
   a_hv: assert property (p_hv) else $error("hv");
   property p_rdy; mem_rd_valid |=> mem_rd_ready; endproperty
   a_rdy: assert property (p_rdy) else $error("rdy");
   property p_top; mem_rd_valid |=> mem_rd_data[31:30] == 2'h0
      && mem_rd_data[27:26] == 2'h0; endproperty
   a_top: assert property (p_top) else $error("top");
   property p_dbe; mem_rd_valid && mem_dbe |=> mem_rd_data[29]; endproperty
   a_dbe: assert property (p_dbe) else $error("dbe");
   property p_lat; mem_rd_valid && mem_dbe |=> ##1 out_hiz [*3]; endproperty
   a_lat: assert property (p_lat) else $error("lat");
   property p_uv; !$past(rst) |-> diagnostic_flags[3]
      == $past(low_supply && !uvd_dis); endproperty
   a_uv: assert property (p_uv) else $error("uv");
   property p_hold; !data_hold |=> !data_hold; endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_fl; $rose(diagnostic_flags[0])
      |-> $past(mem_rd_valid && mem_dbe); endproperty
   a_fl: assert property (p_fl) else $error("fl");
endmodule
bind sfdm_manager sfdm_monitor i_sfdm_monitor (.*);

// File: tb/sfdm_ctrl.sv
// Controller model decoding the fault output
`timescale 1ns/10ps
module sfdm_ctrl (
   // Device output
   input wire out_hiz,
   input wire half_carrier,
   input wire [6:0] pwm_duty,
   // Duty in tens, F when lost
   output wire [3:0] seen_fault
);
   wire [6:0] tens = pwm_duty / 7'hA;
   assign seen_fault = out_hiz ? 4'hF : half_carrier ? tens[3:0] : 4'h0;
endmodule

// File: tb/tb_top.sv
// Bench for the fault manager
`timescale 1ns/10ps
module tb_top;
   reg ref_clk = 0, rst = 1, range_low = 0, range_high = 0, low_supply = 0;
   reg high_supply = 0, high_voltage = 0, over_temp = 0, analog_path_err = 0;
   reg logic_bist_err = 0, hiz_style = 0, nibble_report = 0, ovd_dis = 0;
   reg uvd_dis = 0, otmp_dis = 0, oor_dis = 0, coilbist_dis = 0, lbist_dis = 0;
   reg mem_rd_valid = 0, mem_sbe = 0, mem_dbe = 0;
   reg [3:0] proto_sel = 0;
   reg [2:0] lock_field = 3'h5;
   reg [1:0] coil_rate = 0;
   reg [25:0] mem_raw_data = 0, mem_syndrome = 0;
   wire out_hiz, prog_mode, fault_coded, half_carrier, data_hold, mem_rd_ready;
   wire [6:0] pwm_duty;
   wire [3:0] status_comm_nibble, seen_fault;
   wire [7:0] nibble_faults, diagnostic_flags;
   wire [31:0] mem_rd_data;
   wire [23:0] dg = 24'h987643;
   integer err_total = 0, n_tests = 0, i;
   sfdm_manager #(.PO_CYCLES(20)) i_sfdm_manager (.*);
   sfdm_ctrl i_sfdm_ctrl (.*);
   always #20 ref_clk = ~ref_clk;
   task step(input integer n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task chk(input [32:0] got, exp);
      n_tests = n_tests + 1;
      err_total = err_total + (got !== exp);
      if (got !== exp)
         $display("mismatch %0t %h %h", $time, got, exp);
   endtask
   task flt(input [7:0] f, input [15:0] c);
      {range_high, range_low, over_temp, high_supply, low_supply,
         analog_path_err, logic_bist_err, high_voltage} = f;
      {lock_field, coil_rate, ovd_dis, uvd_dis, otmp_dis, oor_dis,
         coilbist_dis, proto_sel, hiz_style, nibble_report} = c;
      step(1);
   endtask
   task results;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      step(19);
      chk({out_hiz, data_hold}, 2'h3);
      step(1);
      rst = 0;
      step(20);
      chk(data_hold, 1'h1);
      step(3);
      chk({data_hold, out_hiz}, 2'h0);
      $display("reset done");
      for (i = 2; i < 8; i = i + 1)
      begin
         flt(8'h01 << i, 16'hA000);
         chk({diagnostic_flags, seen_fault}, {8'h01 << i, dg[i*4-8 +: 4]});
         flt(8'h01 << i, 16'hA007);
         chk({status_comm_nibble[1:0], nibble_faults},
            {i == 2 ? 2'h1 : 2'h2, 8'h80 >> i});
      end
      flt(8'h90, 16'hA000);
      chk(pwm_duty, 7'h3C);
      flt(8'hFC, 16'hA7C0);
      chk({diagnostic_flags, half_carrier}, 9'h0);
      flt(8'h04, 16'hB800);
      chk({diagnostic_flags, half_carrier}, 9'h0);
      flt(8'h10, 16'h0000);
      chk({prog_mode, out_hiz, diagnostic_flags}, 10'h300);
      flt(8'h08, 16'hA002);
      chk(out_hiz, 1'h1);
      flt(8'h01, 16'hA000);
      chk(out_hiz, 1'h1);
      flt(8'h02, 16'hA000);
      chk({out_hiz, diagnostic_flags}, 9'h102);
      flt(8'h00, 16'hA000);
      chk({out_hiz, half_carrier}, 2'h0);
      $display("codes done");
      {mem_rd_valid, mem_raw_data} = {1'h1, 26'h3FFFFFF};
      step(1);
      chk({mem_rd_ready, mem_rd_data}, 33'h103FFFFFF);
      {mem_sbe, mem_raw_data, mem_syndrome} = {1'h1, 26'h1234567, 26'h10};
      step(1);
      chk({out_hiz, mem_rd_data}, 33'h011234577);
      {mem_sbe, mem_dbe} = 2'h1;
      step(1);
      mem_rd_valid = 0;
      step(1);
      chk({out_hiz, diagnostic_flags}, 9'h101);
      $display("memory done");
      results;
   end
endmodule
